// file: hdl/spt_pkg.sv
// Constants shared by the parallel slave port and its synchroniser
package spt_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] SPT_CTRL_OFS = 8'h00;  // Control and status
    localparam logic [7:0] SPT_DATA_OFS = 8'h04;  // Port data latches
    localparam logic [7:0] SPT_ISTAT_OFS = 8'h08; // Sticky event bits
    localparam logic [7:0] SPT_IMASK_OFS = 8'h0C; // Event mask
    localparam logic [7:0] SPT_CFG_OFS = 8'h10;   // Pin configuration

    // Control and status field positions
    localparam int SPT_IBF_BIT = 7;  // Input full flag
    localparam int SPT_OBF_BIT = 6;  // Output full flag
    localparam int SPT_OVR_BIT = 5;  // Input overrun flag
    localparam int SPT_MODE_BIT = 4; // Slave port mode select

    // Pin configuration field positions
    localparam int SPT_DIR_LSB = 0;  // Control pin direction, 3 bits
    localparam int SPT_ANA_LSB = 4;  // Analog pin select bits, 3 bits
    localparam int SPT_INTMEM_BIT = 7; // Running from internal memory

    // Event bit positions in the status and mask registers
    localparam int SPT_EV_RX = 0;    // Byte received from outside
    localparam int SPT_EV_TX = 1;    // Output byte read by outside
    localparam int SPT_EV_OVR = 2;   // Overrun on receive

    // Reset values
    localparam logic [7:0] SPT_CTRL_RST = 8'h00;  // Mode off, flags clear
    localparam logic [7:0] SPT_CFG_RST = 8'h87;   // Inputs, analog, internal
    localparam logic [2:0] SPT_IMASK_RST = 3'h0;  // All events masked

    // Pin group widths and synchroniser width
    localparam int SPT_DW = 8;       // Data port width
    localparam int SPT_SYNC_W = 11;  // Data plus three strobes

    // AXI response codes
    localparam logic [1:0] SPT_RESP_OKAY = 2'h0;   // Normal access
    localparam logic [1:0] SPT_RESP_SLVERR = 2'h2; // Unmapped address

endpackage : spt_pkg

// file: hdl/spt_sync.sv
// Two flip-flop synchroniser for the asynchronous port pins
`timescale 1ns/1ps
module spt_sync
    import spt_pkg::*;
#(
    parameter int W = SPT_SYNC_W  // Number of bits synchronised
) (
    input wire logic clk,         // Device clock
    input wire logic rst,         // Asynchronous reset, active high
    input wire logic [W-1:0] d,   // Asynchronous pin levels
    output logic [W-1:0] q        // Levels in the clock domain
);

    // Both stages held in one state word
    typedef struct packed {
        logic [W-1:0] s1;  // First stage, read only by the second
        logic [W-1:0] s2;  // Second stage, safe to use
    } spt_sync_t;

    spt_sync_t st_r;   // Current stages
    spt_sync_t st_nxt; // Next stages

    // Shift the pin levels through two stages
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // Register the stages; strobes idle high after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule : spt_sync

// file: hdl/spt_port.sv
// Parallel slave port with AXI4-Lite register access
`timescale 1ns/1ps
module spt_port
    import spt_pkg::*;
(
    input wire logic REF_CLK,           // Device clock, 40 MHz
    input wire logic RST,               // Asynchronous reset, active high
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR,      // Write address
    input wire logic AWVALID,           // Write address valid
    output logic AWREADY,               // Write address ready
    input wire logic [31:0] WDATA,      // Write data
    input wire logic [3:0] WSTRB,       // Write byte strobes
    input wire logic WVALID,            // Write data valid
    output logic WREADY,                // Write data ready
    output logic [1:0] BRESP,           // Write response
    output logic BVALID,                // Write response valid
    input wire logic BREADY,            // Write response ready
    input wire logic [7:0] ARADDR,      // Read address
    input wire logic ARVALID,           // Read address valid
    output logic ARREADY,               // Read address ready
    output logic [31:0] RDATA,          // Read data
    output logic [1:0] RRESP,           // Read response
    output logic RVALID,                // Read data valid
    input wire logic RREADY,            // Read data ready
    // External microprocessor side
    input wire logic RD_N,              // Read strobe, active low
    input wire logic WR_N,              // Write strobe, active low
    input wire logic CS_N,              // Chip select, active low
    input wire logic [7:0] DATA_I,      // Data pin levels
    output logic [7:0] DATA_O,          // Data pin drive value
    output logic DATA_OE,               // Data pin drive enable
    // General-purpose port logic sharing the data pins
    input wire logic [7:0] GPIO_DO,     // General-purpose drive value
    input wire logic GPIO_OE,           // General-purpose drive enable
    output logic SLAVE_ACTIVE,          // Slave port owns the pins
    output logic TTL_SEL,               // TTL thresholds on control pins
    output logic IRQ                    // Interrupt, active high level
);

    // Whole state of the block
    typedef struct packed {
        logic mode;            // Slave port mode select
        logic input_full_flag;             // Input full flag
        logic output_full_flag;             // Output full flag
        logic ovr;             // Input overrun flag
        logic [2:0] dir;       // Control pin direction bits
        logic [2:0] ana;       // Analog pin select bits
        logic intmem;          // Running from internal program memory
        logic act;             // Slave port in effect
        logic [7:0] in_lat;    // Byte written by the outside
        logic [7:0] out_lat;   // Byte for the outside to read
        logic oe;              // Data pins driven by the slave port
        logic wr_prev;         // Write access seen last cycle
        logic rd_prev;         // Read access seen last cycle
        logic [2:0] istat;     // Sticky event bits
        logic [2:0] imask;     // Event mask
        logic aw_full;         // Write address held
        logic [7:0] aw_addr;   // Held write address
        logic w_full;          // Write data held
        logic [7:0] w_data;    // Held write data, low lane
        logic w_lane;          // Low byte strobe of held data
        logic bvalid;          // Write response pending
        logic [1:0] bresp;     // Write response code
        logic rvalid;          // Read data pending
        logic [7:0] rdata;     // Read data, low lane
        logic [1:0] rresp;     // Read response code
    } spt_state_t;

    spt_state_t st_r;    // Current state
    spt_state_t st_nxt;  // Next state

    logic [SPT_SYNC_W-1:0] pin_s; // Synchronised pins
    logic cs_lo;        // Chip select seen low
    logic wr_lo;        // Write strobe seen low
    logic rd_lo;        // Read strobe seen low
    logic [7:0] data_s; // Synchronised data pins
    logic wr_det;       // Write access in progress
    logic rd_det;       // Read access in progress
    logic wr_evt;       // First cycle of a write access
    logic rd_evt;       // First cycle of a read access
    logic do_wr;        // Register write performed this cycle
    logic cpu_drd;      // CPU reads the data register
    logic cpu_dwr;      // CPU writes the data register
    logic ctrl_wr;      // CPU writes the control register
    logic [7:0] ctrl_v; // Control register read value

    // Address decode shared by reads and writes
    function automatic logic spt_mapped(input logic [7:0] a);
        spt_mapped = (a == SPT_CTRL_OFS) || (a == SPT_DATA_OFS) ||
                     (a == SPT_ISTAT_OFS) || (a == SPT_IMASK_OFS) ||
                     (a == SPT_CFG_OFS);
    endfunction : spt_mapped

    // Strobes and data cross into the clock domain
    spt_sync #(
        .W(SPT_SYNC_W)
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .d({CS_N, WR_N, RD_N, DATA_I}),
        .q(pin_s)
    );

    assign cs_lo = ~pin_s[10];
    assign wr_lo = ~pin_s[9];
    assign rd_lo = ~pin_s[8];
    assign data_s = pin_s[7:0];

    // Access detection on the synchronised strobes
    assign wr_det = st_r.act & cs_lo & wr_lo;
    assign rd_det = st_r.act & cs_lo & rd_lo;
    assign wr_evt = wr_det & ~st_r.wr_prev;
    assign rd_evt = rd_det & ~st_r.rd_prev;

    // Bus handshakes
    assign do_wr = st_r.aw_full & st_r.w_full & ~st_r.bvalid;
    assign cpu_dwr = do_wr & st_r.w_lane & (st_r.aw_addr == SPT_DATA_OFS);
    assign ctrl_wr = do_wr & st_r.w_lane & (st_r.aw_addr == SPT_CTRL_OFS);
    assign cpu_drd = ARVALID & ~st_r.rvalid & (ARADDR == SPT_DATA_OFS);

    // Control value; low nibble is unimplemented
    always_comb begin
        ctrl_v = 8'h00;
        ctrl_v[SPT_IBF_BIT] = st_r.input_full_flag;
        ctrl_v[SPT_OBF_BIT] = st_r.output_full_flag;
        ctrl_v[SPT_OVR_BIT] = st_r.ovr;
        ctrl_v[SPT_MODE_BIT] = st_r.mode;
    end

    // Next-state logic for the port, flags and bus slave
    always_comb begin
        st_nxt = st_r;
        // Port in effect only when every enable condition holds
        st_nxt.act = st_r.mode & (&st_r.dir)
                     & (&st_r.ana) & st_r.intmem;
        st_nxt.wr_prev = wr_det;
        st_nxt.rd_prev = rd_det;
        // Drive data pins only during a read window
        st_nxt.oe = rd_det;

        // Write address channel
        if (AWVALID && !st_r.aw_full && !st_r.bvalid) begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_addr = AWADDR;
        end
        // Write data channel
        if (WVALID && !st_r.w_full && !st_r.bvalid) begin
            st_nxt.w_full = 1'b1;
            st_nxt.w_data = WDATA[7:0];
            st_nxt.w_lane = WSTRB[0];
        end
        // Perform the write once address and data are both held
        if (do_wr) begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = spt_mapped(st_r.aw_addr) ? SPT_RESP_OKAY
                                                    : SPT_RESP_SLVERR;
            if (st_r.w_lane) begin
                case (st_r.aw_addr)
                    SPT_CTRL_OFS: begin
                        // Mode bit; clearing it returns general use
                        st_nxt.mode = st_r.w_data[SPT_MODE_BIT];
                        // Overrun cleared by writing zero
                        if (!st_r.w_data[SPT_OVR_BIT]) begin
                            st_nxt.ovr = 1'b0;
                        end
                    end
                    SPT_DATA_OFS: begin
                        // Load the byte the outside will read
                        st_nxt.out_lat = st_r.w_data;
                        if (st_r.act) begin
                            st_nxt.output_full_flag = 1'b1;
                        end
                    end
                    SPT_ISTAT_OFS: begin
                        // Write one to clear
                        st_nxt.istat = st_r.istat & ~st_r.w_data[2:0];
                    end
                    SPT_IMASK_OFS: begin
                        st_nxt.imask = st_r.w_data[2:0];
                    end
                    SPT_CFG_OFS: begin
                        st_nxt.dir = st_r.w_data[SPT_DIR_LSB +: 3];
                        st_nxt.ana = st_r.w_data[SPT_ANA_LSB +: 3];
                        st_nxt.intmem = st_r.w_data[SPT_INTMEM_BIT];
                    end
                    default: begin
                        st_nxt.mode = st_r.mode;
                    end
                endcase
            end
        end
        if (st_r.bvalid && BREADY) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (ARVALID && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = spt_mapped(ARADDR) ? SPT_RESP_OKAY
                                              : SPT_RESP_SLVERR;
            case (ARADDR)
                SPT_CTRL_OFS: st_nxt.rdata = ctrl_v;
                SPT_DATA_OFS: st_nxt.rdata = st_r.in_lat;
                SPT_ISTAT_OFS: st_nxt.rdata = {5'h00, st_r.istat};
                SPT_IMASK_OFS: st_nxt.rdata = {5'h00, st_r.imask};
                SPT_CFG_OFS: st_nxt.rdata = {st_r.intmem, st_r.ana,
                                             1'b0, st_r.dir};
                default: st_nxt.rdata = 8'h00;
            endcase
        end else if (st_r.rvalid && RREADY) begin
            st_nxt.rvalid = 1'b0;
        end

        // CPU read of the data register empties the input latch
        if (cpu_drd) begin
            st_nxt.input_full_flag = 1'b0;
        end
        // Outside read empties the output latch; CPU load wins
        if (rd_evt && !cpu_dwr) begin
            st_nxt.output_full_flag = 1'b0;
        end
        if (rd_evt) begin
            st_nxt.istat[SPT_EV_TX] = 1'b1;
        end
        // Outside write fills the input latch; set beats clear
        if (wr_evt) begin
            st_nxt.in_lat = data_s;
            st_nxt.input_full_flag = 1'b1;
            st_nxt.istat[SPT_EV_RX] = 1'b1;
            if (st_r.input_full_flag) begin
                st_nxt.ovr = 1'b1;
                st_nxt.istat[SPT_EV_OVR] = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_r <= '0;
            st_r.mode <= SPT_CTRL_RST[SPT_MODE_BIT];
            st_r.dir <= SPT_CFG_RST[SPT_DIR_LSB +: 3];
            st_r.ana <= SPT_CFG_RST[SPT_ANA_LSB +: 3];
            st_r.intmem <= SPT_CFG_RST[SPT_INTMEM_BIT];
            st_r.imask <= SPT_IMASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus outputs
    assign AWREADY = ~st_r.aw_full & ~st_r.bvalid;
    assign WREADY = ~st_r.w_full & ~st_r.bvalid;
    assign BVALID = st_r.bvalid;
    assign BRESP = st_r.bresp;
    assign ARREADY = ~st_r.rvalid;
    assign RVALID = st_r.rvalid;
    assign RRESP = st_r.rresp;
    assign RDATA = {24'h000000, st_r.rdata};

    // Pin ownership: slave port or general-purpose logic
    assign DATA_O = st_r.act ? st_r.out_lat : GPIO_DO;
    assign DATA_OE = st_r.act ? st_r.oe : GPIO_OE;
    assign SLAVE_ACTIVE = st_r.act;
    assign TTL_SEL = st_r.act;
    assign IRQ = |(st_r.istat & st_r.imask);

    // Checks on the port behaviour
    default clocking spt_cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    mode_gate_a: assert property (
        st_r.act |-> $past(st_r.mode) && $past(&st_r.dir)
                     && $past(&st_r.ana) && $past(st_r.intmem))
        else $error("slave port active without all enables");

    wr_capture_a: assert property (
        wr_evt |=> st_r.input_full_flag && st_r.in_lat == $past(data_s))
        else $error("external write not captured");

    wr_once_a: assert property (
        wr_evt ##1 (wr_det && !cpu_drd) [*2] |-> st_r.input_full_flag)
        else $error("input full lost during write");

    ovr_set_a: assert property (
        wr_evt && st_r.input_full_flag |=> st_r.ovr ##1 (st_r.ovr || $past(ctrl_wr)))
        else $error("overrun not flagged");

    obf_clear_a: assert property (
        rd_evt && !cpu_dwr |=> !st_r.output_full_flag)
        else $error("output full not cleared by outside read");

    obf_set_a: assert property (
        cpu_dwr && st_r.act |=> st_r.output_full_flag && st_r.out_lat == DATA_O)
        else $error("output full not set by CPU write");

    ibf_clear_a: assert property (
        cpu_drd && !wr_evt |=> !st_r.input_full_flag)
        else $error("input full not cleared by CPU read");

    oe_window_a: assert property (
        st_r.act && DATA_OE |-> $past(cs_lo) && $past(rd_lo))
        else $error("data driven outside read window");

    rsvd_zero_a: assert property (
        ARVALID && ARREADY && ARADDR == SPT_CTRL_OFS
        |=> RVALID && RDATA[3:0] == 4'h0)
        else $error("unimplemented control bits not zero");

    gpio_pins_a: assert property (
        !st_r.mode ##1 !st_r.mode |-> DATA_OE == GPIO_OE)
        else $error("pins not returned to general use");

    // A CPU read of the data register returns the input latch
    rd_data_a: assert property (
        ARVALID && ARREADY && ARADDR == SPT_DATA_OFS
        |=> RDATA[7:0] == $past(st_r.in_lat))
        else $error("data register read wrong byte");

    // Running from external memory keeps the port switched off
    intmem_gate_a: assert property (
        !st_r.intmem |=> !st_r.act)
        else $error("slave port active from external memory");

endmodule : spt_port

// file: dv/spt_upm.sv
// Model of the external microprocessor on the slave port pins
`timescale 1ns/1ps
module spt_upm (
    input wire logic clk,          // Pacing clock
    input wire logic [7:0] data_o, // Device drive value
    input wire logic data_oe,      // Device drive enable
    output logic rd_n,             // Read strobe, active low
    output logic wr_n,             // Write strobe, active low
    output logic cs_n,             // Chip select, active low
    output logic [7:0] data_i      // Resolved pin level
);
    logic drv;          // Host drives the pins
    logic [7:0] dq;     // Host drive value
    logic [7:0] last_r = 8'h00; // Last level, inverted while floating
    // Device drive wins over the host; a floating bus shows a changing pattern
    assign data_i = data_oe ? data_o : (drv ? dq : ~last_r);
    // Track the level for the floating pattern
    always @(posedge clk) begin
        last_r <= data_i;
    end
    // Idle strobes from time zero
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        drv = 1'b0;
        dq = 8'h00;
    end
    // Select and write low together, data steady past detection
    task automatic ext_wr(input logic [7:0] b);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        drv <= 1'b1;
        dq <= b;
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        drv <= 1'b0;
        repeat (3) @(posedge clk); // Strobes seen high between accesses
    endtask : ext_wr
    // Select and read low together, sample the pins late in the window
    task automatic ext_rd(output logic [7:0] b, output logic oe);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        b = data_i;
        oe = data_oe;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : ext_rd
endmodule : spt_upm

// file: dv/tb_top.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ps
module tb_top
    import spt_pkg::*;
;
    logic REF_CLK = 1'b0; // Device clock
    logic RST = 1'b1;     // Reset, active high
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, GPIO_DO = 8'h5A;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [31:0] WDATA = 32'h0; // Write data
    logic [3:0] WSTRB = 4'h1;   // Byte lane zero only
    logic GPIO_OE = 1'b1;       // General-purpose enable
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RD_N, WR_N, CS_N;
    logic DATA_OE, SLAVE_ACTIVE, TTL_SEL, IRQ;
    logic [1:0] BRESP, RRESP;   // Bus responses
    logic [31:0] RDATA, rv;     // Read data and last read
    logic [1:0] rr;             // Last read response
    logic [1:0] br;             // Last write response
    logic [7:0] DATA_I, DATA_O, b, s = 8'h4A, cfg_bad[3];
    logic oe;                   // Device enable seen by host
    int num_errors = 0, samples_checked = 0;
    always #12.5 REF_CLK = ~REF_CLK;
    spt_port i_dut (.REF_CLK(REF_CLK), .RST(RST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .RD_N(RD_N), .WR_N(WR_N), .CS_N(CS_N),
        .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE(DATA_OE),
        .GPIO_DO(GPIO_DO), .GPIO_OE(GPIO_OE), .SLAVE_ACTIVE(SLAVE_ACTIVE),
        .TTL_SEL(TTL_SEL), .IRQ(IRQ));
    spt_upm i_upm (.clk(REF_CLK), .data_o(DATA_O), .data_oe(DATA_OE),
        .rd_n(RD_N), .wr_n(WR_N), .cs_n(CS_N), .data_i(DATA_I));
    // Next pseudo-random byte
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // Expected control word from the four flags
    function automatic logic [31:0] ctl(input logic i, o, v, m);
        return {24'h0, i, o, v, m, 4'h0};
    endfunction : ctl
    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // Compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // Wait ran out
    task automatic tmo();
        num_errors++;
        results();
    endtask : tmo
    // Write one register; address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ga, gw, gb;
        int n;
        @(posedge REF_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        pa = 1;
        pw = 1;
        gb = 0;
        for (n = 0; n < 40 && !gb; n++) begin
            @(negedge REF_CLK);
            ga = pa && AWREADY;
            gw = pw && WREADY;
            gb = !pa && !pw && BVALID;
            br = BRESP;
            @(posedge REF_CLK);
            if (ga) begin
                AWVALID <= 1'b0;
                pa = 0;
            end
            if (gw) begin
                WVALID <= 1'b0;
                pw = 0;
            end
            if (gb) begin
                BREADY <= 1'b0;
            end
        end
        if (!gb) tmo();
    endtask : wr
    // Read one register into rv and rr
    task automatic rd(input logic [7:0] a);
        logic pa, gr;
        int n;
        @(posedge REF_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        pa = 1;
        gr = 0;
        for (n = 0; n < 40 && !gr; n++) begin
            @(negedge REF_CLK);
            gr = !pa && RVALID;
            rv = RDATA;
            rr = RRESP;
            if (pa && ARREADY) begin
                @(posedge REF_CLK);
                ARVALID <= 1'b0;
                pa = 0;
            end else begin
                @(posedge REF_CLK);
            end
            if (gr) RREADY <= 1'b0;
        end
        if (!gr) tmo();
    endtask : rd
    // Main sequence
    initial begin
        cfg_bad = '{8'hF6, 8'h87, 8'h77};
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        // Reset values and an unmapped place
        rd(SPT_CTRL_OFS); chk(rv, 32'h0);
        rd(SPT_CFG_OFS); chk(rv, 32'h87);
        rd(SPT_IMASK_OFS); chk(rv, 32'h0);
        rd(8'h14); chk(rv, 32'h0);
        chk({30'h0, rr}, {30'h0, SPT_RESP_SLVERR});
        chk({SLAVE_ACTIVE, DATA_OE, DATA_O}, {1'b0, GPIO_OE, GPIO_DO});
        // Enter slave mode; low control bits stay zero
        wr(SPT_CFG_OFS, 32'hF7);
        wr(SPT_CTRL_OFS, 32'h1F);
        chk({30'h0, br}, {30'h0, SPT_RESP_OKAY});
        rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 0, 1));
        chk({30'h0, rr}, {30'h0, SPT_RESP_OKAY});
        chk({SLAVE_ACTIVE, TTL_SEL}, 2'h3);
        // Two outside writes: full then overrun
        s = lfsr(s);
        i_upm.ext_wr(s);
        rd(SPT_CTRL_OFS); chk(rv, ctl(1, 0, 0, 1));
        s = lfsr(s);
        i_upm.ext_wr(s);
        rd(SPT_CTRL_OFS); chk(rv, ctl(1, 0, 1, 1));
        rd(SPT_DATA_OFS); chk(rv, {24'h0, s});
        rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 1, 1));
        wr(SPT_CTRL_OFS, 32'h30);
        rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 1, 1));
        wr(SPT_CTRL_OFS, 32'h10);
        rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 0, 1));
        // Events, mask and interrupt
        rd(SPT_ISTAT_OFS); chk(rv, 32'h5);
        wr(SPT_IMASK_OFS, 32'h1);
        chk(IRQ, 1'b1);
        wr(SPT_IMASK_OFS, 32'h2);
        chk(IRQ, 1'b0);
        // No byte strobe stores nothing; unmapped write is refused
        WSTRB <= 4'h0;
        wr(SPT_IMASK_OFS, 32'h7);
        WSTRB <= 4'h1;
        wr(8'h14, 32'hFF);
        chk({30'h0, br}, {30'h0, SPT_RESP_SLVERR});
        rd(SPT_IMASK_OFS); chk(rv, 32'h2);
        wr(SPT_ISTAT_OFS, 32'h7);
        rd(SPT_ISTAT_OFS); chk(rv, 32'h0);
        // CPU bytes read by the outside, random values
        repeat (3) begin
            s = lfsr(s);
            wr(SPT_DATA_OFS, {24'h0, s});
            rd(SPT_CTRL_OFS); chk(rv, ctl(0, 1, 0, 1));
            i_upm.ext_rd(b, oe);
            chk({oe, b}, {1'b1, s});
            chk(DATA_OE, 1'b0);
            rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 0, 1));
            chk(IRQ, 1'b1);
            wr(SPT_ISTAT_OFS, 32'h2);
        end
        // Bad configurations leave the pins to general use
        foreach (cfg_bad[k]) begin
            GPIO_DO <= lfsr(s);
            GPIO_OE <= k[0];
            wr(SPT_CFG_OFS, {24'h0, cfg_bad[k]});
            @(negedge REF_CLK); // Port state settles one edge later
            chk({SLAVE_ACTIVE, DATA_OE, DATA_O},
                {1'b0, GPIO_OE, GPIO_DO});
            i_upm.ext_wr(8'hC3);
            rd(SPT_CTRL_OFS); chk(rv, ctl(0, 0, 0, 1));
        end
        wr(SPT_CFG_OFS, 32'hF7);
        wr(SPT_CTRL_OFS, 32'h00);
        @(negedge REF_CLK); // Port state settles one edge later
        chk({SLAVE_ACTIVE, TTL_SEL, DATA_OE}, {2'h0, GPIO_OE});
        results();
    end
endmodule : tb_top
